// File: verilog/setup_pkg.sv
// Package with object indexes, command codes, field positions and carriers for the setup sequencer.
package setup_pkg;

  // ----------------------------------------------------------------------
  // Object dictionary indexes and subindexes
  // ----------------------------------------------------------------------
  localparam logic [15:0] OBJ_CONTROLWORD = 16'h6040;
  localparam logic [15:0] OBJ_STATUSWORD = 16'h6041;
  localparam logic [15:0] OBJ_VEL_TARGET = 16'h6042;
  localparam logic [15:0] OBJ_MODE_SELECT = 16'h6060;
  localparam logic [15:0] OBJ_STORE_PARAMS = 16'h1010;
  localparam logic [15:0] OBJ_FB_ASSIGN = 16'h3203;
  localparam logic [15:0] OBJ_FB_SENSORLESS = 16'h3380;
  localparam logic [15:0] OBJ_FB_HALL = 16'h3390;
  localparam logic [15:0] OBJ_FB_ENCODER1 = 16'h33A0;
  localparam logic [15:0] OBJ_ENC_INCREMENTS = 16'h60E6;
  localparam logic [15:0] OBJ_ENC_REVS = 16'h60EB;
  localparam logic [15:0] OBJ_GEAR_RATIO = 16'h60E8;
  localparam logic [15:0] OBJ_FEED_CONST = 16'h60E9;
  localparam logic [7:0] SUB_ZERO = 8'h00;
  localparam logic [7:0] SUB_STORE_DRIVE = 8'h05;
  localparam logic [7:0] SUB_STORE_TUNING = 8'h06;

  // ----------------------------------------------------------------------
  // Values written to objects, and controlword and statusword bit positions
  // ----------------------------------------------------------------------
  localparam logic [31:0] MODE_AUTO_SETUP = 32'hFFFF_FFFE;
  localparam logic [31:0] MODE_VELOCITY = 32'h0000_0002;
  localparam logic [31:0] CW_SHUTDOWN = 32'h0000_0006;
  localparam logic [31:0] CW_SWITCH_ON = 32'h0000_0007;
  localparam logic [31:0] CW_ENABLE_OP = 32'h0000_000F;
  localparam int CW_OMS_BIT = 4;
  localparam int SW_TARGET_BIT = 10;
  localparam int SW_DONE_BIT = 12;
  localparam logic [3:0] SW_STATE_MASK = 4'hF;
  localparam logic [3:0] SW_STATE_OP_EN = 4'h7;

  // ----------------------------------------------------------------------
  // Software register map of the controller
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_VEL = 4'h2;
  localparam logic [3:0] REG_STATWORD = 4'h3;
  localparam logic [3:0] REG_OBJ_CMD = 4'h4;
  localparam logic [3:0] REG_OBJ_DATA = 4'h5;
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_RUN = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_OBJ = 3;
  localparam int CTRL_OBJ_RD = 4;
  localparam int CTRL_CLR_ERR = 5;

  // ----------------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int POLL_GAP_US = 100;
  localparam int POLL_GAP_CYC = POLL_GAP_US * (CLK_HZ / 1_000_000);
  localparam int BIT_TICK_DIV = 4;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic write;
    logic [15:0] index;
    logic [7:0] sub;
    logic [31:0] data;
  } obj_req_s;

  typedef struct packed {
    logic ok;
    logic [31:0] data;
  } obj_rsp_s;

  // Frame length on the serial object link: write flag, index, subindex, data.
  localparam int REQ_BITS = $bits(obj_req_s);
  localparam int RSP_BITS = $bits(obj_rsp_s);

endpackage

// File: verilog/tick_divider.sv
// Divider that makes a one-cycle enable pulse every DIV clock cycles.
`timescale 1ns/1ns
module tick_divider
  import setup_pkg::*;
#(
  parameter int DIV = BIT_TICK_DIV
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic run,
  output logic tick
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // The count restarts when the link goes idle so the first tick has a fixed phase.
  always_comb
  begin
    cnt_nxt = 8'h00;
    tick_nxt = 1'b0;
    if (run)
    begin
      if (cnt_r == 8'(DIV - 1))
      begin
        tick_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule

// File: verilog/obj_link.sv
// Serial object access engine: shifts a request frame out and a response frame in.
`timescale 1ns/1ns
module obj_link
  import setup_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic start,
  input obj_req_s req,
  output logic busy,
  output logic done,
  output obj_rsp_s rsp,
  output logic link_sel_n,
  output logic link_mosi,
  input wire logic link_miso_sync
);

  typedef enum {L_IDLE, L_SEND, L_WAIT, L_RECV, L_DONE} link_state_e;

  link_state_e st_r;
  link_state_e st_nxt;
  logic [REQ_BITS-1:0] sh_r;
  logic [REQ_BITS-1:0] sh_nxt;
  logic [RSP_BITS-1:0] rx_r;
  logic [RSP_BITS-1:0] rx_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;

  // Frame: request bits MSB first; the device answers with a start bit then the response.
  // The device may take unbounded time while it measures, so the wait for the start bit has no timeout.
  always_comb
  begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    rx_nxt = rx_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      L_IDLE:
      begin
        if (start)
        begin
          sh_nxt = req;
          cnt_nxt = 8'(REQ_BITS - 1);
          st_nxt = L_SEND;
        end
      end
      L_SEND:
      begin
        if (tick)
        begin
          sh_nxt = {sh_r[REQ_BITS-2:0], 1'b0};
          if (cnt_r == 8'h00)
          begin
            st_nxt = L_WAIT;
          end
          else
          begin
            cnt_nxt = cnt_r - 8'h01;
          end
        end
      end
      L_WAIT:
      begin
        if (tick && link_miso_sync)
        begin
          cnt_nxt = 8'(RSP_BITS - 1);
          st_nxt = L_RECV;
        end
      end
      L_RECV:
      begin
        if (tick)
        begin
          rx_nxt = {rx_r[RSP_BITS-2:0], link_miso_sync};
          if (cnt_r == 8'h00)
          begin
            st_nxt = L_DONE;
          end
          else
          begin
            cnt_nxt = cnt_r - 8'h01;
          end
        end
      end
      L_DONE:
      begin
        st_nxt = L_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= L_IDLE;
      sh_r <= '0;
      rx_r <= '0;
      cnt_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      rx_r <= rx_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Outputs decoded from registered state; the top registers link_sel_n and link_mosi again.
  assign busy = (st_r != L_IDLE);
  assign done = (st_r == L_DONE);
  assign rsp = rx_r;
  assign link_sel_n = !(st_r == L_SEND || st_r == L_WAIT || st_r == L_RECV);
  assign link_mosi = (st_r == L_SEND) ? sh_r[REQ_BITS-1] : 1'b0;

endmodule

// File: verilog/motor_auto_setup_sequencer.sv
// Host-side sequencer that runs the motor auto setup and a velocity test run over the object link.
`timescale 1ns/1ns
module motor_auto_setup_sequencer
  import setup_pkg::*;
#(
  parameter int POLL_CYCLES = POLL_GAP_CYC
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic link_sel_n,
  output logic link_mosi,
  input wire logic link_miso,
  output logic restart_req
);

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum {S_IDLE, S_SHUT, S_SWON, S_ENAB, S_CHECK, S_OMS, S_GAP, S_POLL, S_VEL,
                S_STOP, S_OBJ, S_XFER, S_READ} seq_state_e;

  seq_state_e st_r;
  seq_state_e st_nxt;
  seq_state_e ret_r;
  seq_state_e ret_nxt;
  logic auto_r;
  logic auto_nxt;
  logic busy_r;
  logic busy_nxt;
  logic done_r;
  logic done_nxt;
  logic index_r;
  logic index_nxt;
  logic err_r;
  logic err_nxt;
  logic restart_r;
  logic restart_nxt;
  logic [31:0] vel_r;
  logic [31:0] vel_nxt;
  logic [31:0] sw_r;
  logic [31:0] sw_nxt;
  logic [31:0] ocmd_r;
  logic [31:0] ocmd_nxt;
  logic [31:0] odata_r;
  logic [31:0] odata_nxt;
  logic [31:0] gap_r;
  logic [31:0] gap_nxt;
  obj_req_s req_r;
  obj_req_s req_nxt;
  logic go_r;
  logic go_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic sel_n_r;
  logic mosi_r;
  logic miso_meta_r;
  logic miso_sync_r;
  logic tick;
  logic lk_busy;
  logic lk_done;
  obj_rsp_s lk_rsp;
  logic lk_sel_n;
  logic lk_mosi;

  // Builds one object request so every sequence step reads alike.
  function automatic obj_req_s mk_req(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                                      input logic [31:0] val);
    obj_req_s r;
    r.write = wr;
    r.index = idx;
    r.sub = sub;
    r.data = val;
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Link pin synchroniser
  // ----------------------------------------------------------------------
  // The response pin arrives from outside; only the second flop is used.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      miso_meta_r <= 1'b0;
      miso_sync_r <= 1'b0;
    end
    else
    begin
      miso_meta_r <= link_miso;
      miso_sync_r <= miso_meta_r;
    end
  end

  tick_divider #(.DIV(BIT_TICK_DIV)) u_div (
    .core_clk(core_clk),
    .rst(rst),
    .run(lk_busy),
    .tick(tick)
  );

  // Encapsulated object access carries every transfer, inside or outside the process image.
  obj_link u_link (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick),
    .start(go_r),
    .req(req_r),
    .busy(lk_busy),
    .done(lk_done),
    .rsp(lk_rsp),
    .link_sel_n(lk_sel_n),
    .link_mosi(lk_mosi),
    .link_miso_sync(miso_sync_r)
  );

  // ----------------------------------------------------------------------
  // Sequencer and register file next state
  // ----------------------------------------------------------------------
  // Each write to an object other than the statusword is followed by a statusword read back before going on.
  always_comb
  begin
    st_nxt = st_r;
    ret_nxt = ret_r;
    auto_nxt = auto_r;
    busy_nxt = busy_r;
    done_nxt = done_r;
    index_nxt = index_r;
    err_nxt = err_r;
    restart_nxt = restart_r;
    vel_nxt = vel_r;
    sw_nxt = sw_r;
    ocmd_nxt = ocmd_r;
    odata_nxt = odata_r;
    gap_nxt = gap_r;
    req_nxt = req_r;
    go_nxt = 1'b0;
    rdata_nxt = 32'h0000_0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        REG_STATUS: rdata_nxt = {27'h0, restart_r, err_r, index_r, done_r, busy_r};
        REG_VEL: rdata_nxt = vel_r;
        REG_STATWORD: rdata_nxt = sw_r;
        REG_OBJ_CMD: rdata_nxt = ocmd_r;
        REG_OBJ_DATA: rdata_nxt = odata_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    if (reg_wr)
    begin
      if (reg_addr == REG_VEL)
      begin
        vel_nxt = reg_wdata;
      end
      if (reg_addr == REG_OBJ_CMD)
      begin
        ocmd_nxt = reg_wdata;
      end
      if (reg_addr == REG_OBJ_DATA)
      begin
        odata_nxt = reg_wdata;
      end
      if (reg_addr == REG_CTRL && reg_wdata[CTRL_CLR_ERR])
      begin
        err_nxt = 1'b0;
      end
    end
    unique case (st_r)
      S_IDLE:
      begin
        if (reg_wr && reg_addr == REG_CTRL)
        begin
          if (reg_wdata[CTRL_AUTO])
          begin
            auto_nxt = 1'b1;
            busy_nxt = 1'b1;
            done_nxt = 1'b0;
            req_nxt = mk_req(1'b1, OBJ_MODE_SELECT, SUB_ZERO, MODE_AUTO_SETUP);
            st_nxt = S_XFER;
            ret_nxt = S_SHUT;
          end
          else if (reg_wdata[CTRL_RUN])
          begin
            auto_nxt = 1'b0;
            busy_nxt = 1'b1;
            req_nxt = mk_req(1'b1, OBJ_MODE_SELECT, SUB_ZERO, MODE_VELOCITY);
            st_nxt = S_XFER;
            ret_nxt = S_VEL;
          end
          else if (reg_wdata[CTRL_STOP])
          begin
            busy_nxt = 1'b1;
            st_nxt = S_STOP;
          end
          else if (reg_wdata[CTRL_OBJ])
          begin
            // Resolution, gear, feed and feedback-assignment objects go here.
            busy_nxt = 1'b1;
            req_nxt = mk_req(!reg_wdata[CTRL_OBJ_RD], ocmd_r[23:8], ocmd_r[7:0], odata_r);
            st_nxt = S_XFER;
            ret_nxt = S_OBJ;
          end
        end
      end
      S_VEL:
      begin
        // Target speed lands before the power stage is enabled.
        req_nxt = mk_req(1'b1, OBJ_VEL_TARGET, SUB_ZERO, vel_r);
        st_nxt = S_XFER;
        ret_nxt = S_SHUT;
      end
      S_SHUT:
      begin
        req_nxt = mk_req(1'b1, OBJ_CONTROLWORD, SUB_ZERO, CW_SHUTDOWN);
        st_nxt = S_XFER;
        ret_nxt = S_SWON;
      end
      S_SWON:
      begin
        req_nxt = mk_req(1'b1, OBJ_CONTROLWORD, SUB_ZERO, CW_SWITCH_ON);
        st_nxt = S_XFER;
        ret_nxt = S_ENAB;
      end
      S_ENAB:
      begin
        req_nxt = mk_req(1'b1, OBJ_CONTROLWORD, SUB_ZERO, CW_ENABLE_OP);
        st_nxt = S_XFER;
        ret_nxt = S_CHECK;
      end
      S_CHECK:
      begin
        // Operation enabled must be confirmed before the start bit is raised.
        if ((sw_r[3:0] & SW_STATE_MASK) != SW_STATE_OP_EN)
        begin
          err_nxt = 1'b1;
          busy_nxt = 1'b0;
          st_nxt = S_IDLE;
        end
        else if (auto_r)
        begin
          st_nxt = S_OMS;
        end
        else
        begin
          busy_nxt = 1'b0;
          st_nxt = S_IDLE;
        end
      end
      S_OMS:
      begin
        req_nxt = mk_req(1'b1, OBJ_CONTROLWORD, SUB_ZERO, CW_ENABLE_OP | (32'h1 << CW_OMS_BIT));
        st_nxt = S_XFER;
        ret_nxt = S_GAP;
        gap_nxt = 32'(POLL_CYCLES);
      end
      S_GAP:
      begin
        // Polls are spaced out because the device is busy measuring; no timeout is kept.
        if (gap_r == 32'h0)
        begin
          req_nxt = mk_req(1'b0, OBJ_STATUSWORD, SUB_ZERO, 32'h0);
          st_nxt = S_XFER;
          ret_nxt = S_POLL;
        end
        else
        begin
          gap_nxt = gap_r - 32'h1;
        end
      end
      S_POLL:
      begin
        if (sw_r[SW_DONE_BIT])
        begin
          done_nxt = 1'b1;
          index_nxt = sw_r[SW_TARGET_BIT];
          restart_nxt = 1'b1;
          busy_nxt = 1'b0;
          st_nxt = S_IDLE;
        end
        else
        begin
          gap_nxt = 32'(POLL_CYCLES);
          st_nxt = S_GAP;
        end
      end
      S_STOP:
      begin
        req_nxt = mk_req(1'b1, OBJ_CONTROLWORD, SUB_ZERO, CW_SHUTDOWN);
        st_nxt = S_XFER;
        ret_nxt = S_OBJ;
      end
      S_OBJ:
      begin
        if (!req_r.write || req_r.index == OBJ_STATUSWORD)
        begin
          odata_nxt = lk_rsp.data;
        end
        busy_nxt = 1'b0;
        st_nxt = S_IDLE;
      end
      S_XFER:
      begin
        if (!lk_busy && !go_r)
        begin
          go_nxt = 1'b1;
          st_nxt = S_READ;
        end
      end
      S_READ:
      begin
        if (lk_done)
        begin
          if (!lk_rsp.ok)
          begin
            err_nxt = 1'b1;
            busy_nxt = 1'b0;
            st_nxt = S_IDLE;
          end
          else if (req_r.write && req_r.index != OBJ_STATUSWORD)
          begin
            // Confirm the write by reading the statusword back.
            req_nxt = mk_req(1'b0, OBJ_STATUSWORD, SUB_ZERO, 32'h0);
            st_nxt = S_XFER;
          end
          else
          begin
            sw_nxt = (req_r.index == OBJ_STATUSWORD) ? lk_rsp.data : sw_r;
            st_nxt = ret_r;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= S_IDLE;
      ret_r <= S_IDLE;
      auto_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      index_r <= 1'b0;
      err_r <= 1'b0;
      restart_r <= 1'b0;
      vel_r <= 32'h0000_0000;
      sw_r <= 32'h0000_0000;
      ocmd_r <= 32'h0000_0000;
      odata_r <= 32'h0000_0000;
      gap_r <= 32'h0000_0000;
      req_r <= '0;
      go_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      sel_n_r <= 1'b1;
      mosi_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      ret_r <= ret_nxt;
      auto_r <= auto_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      index_r <= index_nxt;
      err_r <= err_nxt;
      restart_r <= restart_nxt;
      vel_r <= vel_nxt;
      sw_r <= sw_nxt;
      ocmd_r <= ocmd_nxt;
      odata_r <= odata_nxt;
      gap_r <= gap_nxt;
      req_r <= req_nxt;
      go_r <= go_nxt;
      rdata_r <= rdata_nxt;
      sel_n_r <= lk_sel_n;
      mosi_r <= lk_mosi;
    end
  end

  // Outputs straight from flops; restart request stays until reset.
  assign reg_rdata = rdata_r;
  assign link_sel_n = sel_n_r;
  assign link_mosi = mosi_r;
  assign restart_req = restart_r;

endmodule

// File: tb/device_model.sv
// Behavioural model of the drive as seen across the serial object link.
`timescale 1ns/1ns
module device_model
  import setup_pkg::*;
(
  input wire logic core_clk,
  input wire logic link_sel_n,
  input wire logic link_mosi,
  output logic link_miso,
  input wire logic idx_present,
  input wire logic refuse_en
);
  logic [31:0] mode_r, cw_r, vel_r, sw_r, wr_data_r;
  logic [15:0] wr_idx_r;
  logic [1:0] stored_r;
  int setup_left;
  obj_req_s req;
  obj_rsp_s rsp;

  // ----------------------------------------------------------------------
  // Object dictionary behaviour
  // ----------------------------------------------------------------------
  // Applies one request frame and prepares the answer.
  task automatic apply();
    rsp = {1'b1, 32'h0};
    if (req.write)
    begin
      case (req.index)
        OBJ_MODE_SELECT: mode_r = req.data;
        OBJ_VEL_TARGET: vel_r = req.data;
        OBJ_CONTROLWORD:
        begin
          // The start is edge triggered on the mode bit, so a held bit never restarts.
          if (mode_r == MODE_AUTO_SETUP && req.data[CW_OMS_BIT] && !cw_r[CW_OMS_BIT] && sw_r[3:0] == SW_STATE_OP_EN)
          begin
            sw_r[SW_DONE_BIT] = 1'b0;
            setup_left = 3;
          end
          cw_r = req.data;
          sw_r[3:0] = (req.data[3:0] == 4'hF && !refuse_en) ? SW_STATE_OP_EN : ((req.data[3:0] == 4'h7) ? 4'h3 : 4'h1);
        end
        default:
        begin
          wr_idx_r = req.index;
          wr_data_r = req.data;
        end
      endcase
    end
    else if (req.index == OBJ_STATUSWORD)
    begin
      if (setup_left == 1)
      begin
        sw_r[SW_DONE_BIT] = 1'b1;
        sw_r[SW_TARGET_BIT] = idx_present;
        stored_r = 2'b11;
      end
      if (setup_left > 0)
        setup_left--;
      rsp.data = sw_r;
    end
  endtask

  // ----------------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------------
  // Samples on falling edges, half a cycle after the host's flops change, so it never races them.
  initial
  begin
    link_miso = 1'b0;
    {mode_r, cw_r, vel_r, sw_r, wr_data_r, wr_idx_r, stored_r} = '0;
    setup_left = 0;
    forever
    begin
      @(negedge link_sel_n);
      repeat (2) @(negedge core_clk);
      for (int i = REQ_BITS - 1; i >= 0; i--)
      begin
        req[i] = link_mosi;
        repeat (4) @(negedge core_clk);
      end
      apply();
      // A running setup answers slowly, as the processor is loaded.
      repeat ((setup_left > 0) ? 40 : 3) @(negedge core_clk);
      link_miso = 1'b1;
      repeat (4) @(negedge core_clk);
      for (int i = RSP_BITS - 1; i >= 0; i--)
      begin
        link_miso = rsp[i];
        repeat (4) @(negedge core_clk);
      end
      // The line is pulled low once released.
      link_miso = 1'b0;
      wait (link_sel_n);
    end
  end
endmodule

// File: tb/motor_auto_setup_sequencer_sva.sv
// Checker with concurrent assertions on the sequencer's ports.
`timescale 1ns/1ns
module seq_checker
  import setup_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic link_sel_n,
  input wire logic link_mosi,
  input wire logic restart_req
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  property p_rdata_quiet; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data not zero outside a read answer");
  property p_unmapped; reg_rd && reg_addr > REG_OBJ_DATA |=> reg_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_restart_sticky; restart_req |=> restart_req; endproperty
  a_restart_sticky: assert property (p_restart_sticky) else $error("restart request dropped");
  property p_restart_status; reg_rd && reg_addr == REG_STATUS |=> reg_rdata[4] == restart_req; endproperty
  a_restart_status: assert property (p_restart_status) else $error("restart status bit mismatch");
  property p_done_restart; reg_rd && reg_addr == REG_STATUS ##1 reg_rdata[1] |-> reg_rdata[4] && restart_req; endproperty
  a_done_restart: assert property (p_done_restart) else $error("done without restart request");
  property p_restart_frame; $rose(restart_req) |-> link_sel_n; endproperty
  a_restart_frame: assert property (p_restart_frame) else $error("restart raised inside a frame");
  property p_mosi_idle; link_sel_n |-> !link_mosi; endproperty
  a_mosi_idle: assert property (p_mosi_idle) else $error("request line active outside frame");
  property p_frame_min; $fell(link_sel_n) |-> !link_sel_n [*8]; endproperty
  a_frame_min: assert property (p_frame_min) else $error("frame select too short");
  property p_bit_hold; !link_sel_n && $changed(link_mosi) |=> ($stable(link_mosi) || link_sel_n) [*3]; endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("request bit shorter than four cycles");
endmodule

bind motor_auto_setup_sequencer seq_checker u_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_sel_n(link_sel_n), .link_mosi(link_mosi),
  .restart_req(restart_req));

// File: tb/motor_auto_setup_sequencer_tb.sv
// Self-checking testbench for the auto setup sequencer.
`timescale 1ns/1ns
module motor_auto_setup_sequencer_tb;
  import setup_pkg::*;
  logic core_clk, rst, reg_wr, reg_rd, link_sel_n, link_mosi, link_miso, restart_req, idx_present, refuse_en;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val, val;
  int bad_count, samples_checked;

  motor_auto_setup_sequencer #(.POLL_CYCLES(20)) dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_sel_n(link_sel_n),
    .link_mosi(link_mosi), .link_miso(link_miso), .restart_req(restart_req));
  device_model pm (.core_clk(core_clk), .link_sel_n(link_sel_n), .link_mosi(link_mosi), .link_miso(link_miso),
    .idx_present(idx_present), .refuse_en(refuse_en));

  // ----------------------------------------------------------------------
  // Clock, tasks and verdict
  // ----------------------------------------------------------------------
  // Free-running core clock.
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bus tasks end one edge after the strobe drops, so strobes never get two values in one step.
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic reg_read(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    @(posedge core_clk);
  endtask

  // Issues a command and polls busy with a bounded count.
  task automatic run_cmd(input logic [31:0] c);
    reg_write(REG_CTRL, c);
    for (int i = 0; i < 2000; i++)
    begin
      reg_read(REG_STATUS);
      if (rd_val[0] === 1'b0)
        break;
      repeat (50) @(posedge core_clk);
    end
    check({31'h0, rd_val[0]}, 32'h0);
  endtask

  task automatic final_report();
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog sized well above the expected run length.
  initial
  begin
    repeat (90000) @(posedge core_clk);
    bad_count++;
    final_report();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, idx_present, refuse_en} = '0;
    rst = 1'b1;
    bad_count = 0;
    samples_checked = 0;
    void'($urandom(32'h009094D6));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    reg_read(REG_STATUS);
    check(rd_val, 32'h0);
    // Unmapped places ignore writes and read as zero.
    for (int a = 6; a < 16; a++)
    begin
      reg_write(a[3:0], $urandom);
      reg_read(a[3:0]);
      check(rd_val, 32'h0);
    end
    // Two setups: first without an index, then with one.
    for (int k = 0; k < 2; k++)
    begin
      idx_present <= k[0];
      run_cmd(32'h1 << CTRL_AUTO);
      check(rd_val & 32'h1F, {27'h0, 1'b1, 1'b0, k[0], 2'b10});
      reg_read(REG_STATWORD);
      check({30'h0, rd_val[SW_DONE_BIT], rd_val[SW_TARGET_BIT]}, {30'h0, 1'b1, k[0]});
      check(pm.mode_r, MODE_AUTO_SETUP);
      check({31'h0, pm.cw_r[CW_OMS_BIT]}, 32'h1);
      check({30'h0, pm.stored_r}, 32'h3);
      check({31'h0, restart_req}, 32'h1);
    end
    // Velocity test run with a random target, then stop.
    val = $urandom;
    reg_write(REG_VEL, val);
    reg_read(REG_VEL);
    check(rd_val, val);
    run_cmd(32'h1 << CTRL_RUN);
    check(pm.mode_r, MODE_VELOCITY);
    check(pm.vel_r, val);
    check({28'h0, pm.sw_r[3:0]}, {28'h0, SW_STATE_OP_EN});
    run_cmd(32'h1 << CTRL_STOP);
    check(pm.cw_r, CW_SHUTDOWN);
    // Encapsulated object write of the encoder resolution, then a status read back.
    val = $urandom;
    reg_write(REG_OBJ_CMD, {8'h0, OBJ_ENC_INCREMENTS, SUB_ZERO});
    reg_write(REG_OBJ_DATA, val);
    run_cmd(32'h1 << CTRL_OBJ);
    check({16'h0, pm.wr_idx_r}, {16'h0, OBJ_ENC_INCREMENTS});
    check(pm.wr_data_r, val);
    reg_write(REG_OBJ_CMD, {8'h0, OBJ_STATUSWORD, SUB_ZERO});
    run_cmd((32'h1 << CTRL_OBJ) | (32'h1 << CTRL_OBJ_RD));
    reg_read(REG_OBJ_DATA);
    check(rd_val, pm.sw_r);
    // Drive refuses operation enabled: setup must abort with an error.
    refuse_en <= 1'b1;
    run_cmd(32'h1 << CTRL_AUTO);
    check({31'h0, rd_val[3]}, 32'h1);
    refuse_en <= 1'b0;
    reg_write(REG_CTRL, 32'h1 << CTRL_CLR_ERR);
    reg_read(REG_STATUS);
    check({31'h0, rd_val[3]}, 32'h0);
    final_report();
  end
endmodule
